// ---- common/serial_port_params.svh ----
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

// Register indices; byte address is four times the index
`define MC_IDX 8'h00
`define CB_IDX 8'h04
`define IE_IDX 8'h16
`define IF_IDX 8'h18
`define ST_IDX 8'h1a
`define DATA_IDX 8'h28

// main_control fields
`define MC_RESET 32'h0000_0000
`define MC_WMASK 32'h7ff3_e09f
`define MC_PROT_FREE 32'h0000_0003
`define MC_SOFTWARE_RESET 0
`define MC_ENABLE 1
`define MC_COMMUNICATION_MODE_SELECT 28
`define MC_CLOCK_POLARITY_SELECT 29
`define MC_BIT_ORDER_SELECT 30

// Second control word
`define CB_START_FRAME_DETECT_ENABLE 9
`define CB_TXEN 16
`define CB_RXEN 17

// interrupt_flags and interrupt_enable layout
`define FL_DRE 0
`define FL_TXC 1
`define FL_RXC 2
`define FL_RXS 3
`define FL_CTS 4

// port_status fields
`define ST_OVF 0
`define ST_CTS 1
`define ST_TXBUSY 2
`define ST_RXBUSY 3
`define ST_SYNCBUSY 15

// Clock cycles per serial bit
`define BAUD_DIV_DEF 16

`endif

// ---- common/serial_port_pkg.sv ----
package serial_port_pkg;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } rx_state_t;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_LAST = 5'b01000,
    TX_STOP = 5'b10000
  } tx_state_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic start_frame_detect_enable;
    logic txen;
    logic rxen;
    logic [7:0] ie;
    logic cts_f;
    logic rxs_f;
    logic txc_f;
    logic rx_full;
    logic tx_pend;
    logic ovf;
    logic [7:0] txbuf;
    logic [7:0] rxbuf;
    logic [7:0] rsh;
    logic [2:0] rcnt;
    rx_state_t rxst;
    logic [15:0] div;
    logic [15:0] rdiv;
    logic [2:0] cts_s;
    logic [2:0] rxd_s;
    logic wr_pend;
    logic [7:0] aidx;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic irq;
  } main_state_t;

  typedef struct packed {
    tx_state_t st;
    logic [7:0] sh;
    logic [2:0] cnt;
    logic txd;
    logic xck;
    logic done;
  } shifter_state_t;

endpackage

// ---- src/serial_shifter.sv ----
`timescale 1ns/1ns
`include "serial_port_params.svh"
module serial_shifter
  import serial_port_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic mid,
  input wire logic run,
  input wire logic load,
  input wire logic [7:0] data,
  input wire logic lsb_first,
  input wire logic sync_mode,
  input wire logic clock_polarity_select,
  output logic txd,
  output logic xck,
  output logic busy,
  output logic done
);

  localparam shifter_state_t SH_RST = '{st: TX_IDLE, txd: 1'b1, default: '0};

  shifter_state_t r, n;
  logic nbit;

  always_comb begin
    n = r;
    n.done = 1'b0;
    nbit = lsb_first ? r.sh[0] : r.sh[7];
    if (tick) begin
      n.xck = clock_polarity_select;
    end
    case (r.st)
      TX_IDLE: begin
        n.txd = 1'b1;
        n.xck = clock_polarity_select;
        if (load) begin
          n.sh = data;
          n.st = TX_START;
        end
      end
      TX_START: begin
        if (tick) begin
          n.txd = sync_mode ? 1'b1 : 1'b0;
          n.cnt = 3'h0;
          n.st = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tick) begin
          n.txd = nbit;
          n.sh = lsb_first ? {1'b0, r.sh[7:1]} : {r.sh[6:0], 1'b0};
          n.cnt = 3'(r.cnt + 3'h1);
          if (r.cnt == 3'h7) begin
            n.st = TX_LAST;
          end
        end
      end
      TX_LAST: begin
        if (tick) begin
          n.txd = 1'b1;
          n.done = sync_mode;
          n.st = sync_mode ? TX_IDLE : TX_STOP;
        end
      end
      TX_STOP: begin
        if (tick) begin
          n.done = 1'b1;
          n.st = TX_IDLE;
        end
      end
      default: n.st = TX_IDLE;
    endcase
    // Sampling edge at mid-bit of each data bit only, never in the idle bit
    if (mid && sync_mode && ((r.st == TX_DATA && r.cnt != 3'h0) || r.st == TX_LAST)) begin
      n.xck = ~clock_polarity_select;
    end
    if (!run) begin
      n.st = TX_IDLE;
      n.txd = 1'b1;
      n.xck = clock_polarity_select;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= SH_RST;
    end else begin
      r <= n;
    end
  end

  assign txd = r.txd;
  assign xck = r.xck;
  assign done = r.done;
  assign busy = (r.st != TX_IDLE);

  a_bit_order: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == TX_DATA && tick && run) |=> (txd == $past(nbit)))
    else $error("transmitted bit not in selected order");

  a_clock_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (sync_mode && tick && run) |=> (xck == $past(clock_polarity_select)))
    else $error("serial clock not at polarity level after bit change");

endmodule // serial_shifter

// ---- src/serial_port_control_and_flags.sv ----
`timescale 1ns/1ns
`include "serial_port_params.svh"
module serial_port_control_and_flags
  import serial_port_pkg::*;
#(
  parameter int BAUD_DIV = `BAUD_DIV_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic rxd,
  input wire logic cts,
  output logic txd,
  output logic xck,
  output logic irq
);

  localparam main_state_t MAIN_RST = '{
    ctrl: `MC_RESET,
    rxst: RX_IDLE,
    rxd_s: 3'h7,
    hready: 1'b1,
    default: '0
  };

  main_state_t r, n;
  logic en, rx_on, tick, mid, rmid;
  logic cts_chg, start_det, rx_done;
  logic sh_busy, sh_done, sh_load;
  logic addr_ph, addr_ok, rd_data;
  logic wr_mc, wr_cb, wr_ie, wr_if, wr_st, wr_data;
  logic [7:0] a_idx;
  logic [31:0] rdat;
  logic [31:0] mc_wval;

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
    return idx == reg_idx;
  endfunction

  // Flag byte in interrupt_flags layout
  function automatic logic [7:0] flags(input main_state_t s);
    logic [7:0] f;
    f = 8'h00;
    f[`FL_DRE] = ~s.tx_pend;
    f[`FL_TXC] = s.txc_f;
    f[`FL_RXC] = s.rx_full;
    f[`FL_RXS] = s.rxs_f;
    f[`FL_CTS] = s.cts_f;
    return f;
  endfunction

  always_comb begin
    en = r.ctrl[`MC_ENABLE];
    rx_on = en && r.rxen;
    tick = (r.div == 16'(BAUD_DIV - 1));
    mid = (r.div == 16'(BAUD_DIV / 2 - 1));
    rmid = (r.rdiv == 16'(BAUD_DIV / 2 - 1));
    cts_chg = en && (r.cts_s[1] ^ r.cts_s[2]);
    start_det = rx_on && (r.rxst == RX_IDLE) && r.rxd_s[2] && !r.rxd_s[1] && !r.ctrl[`MC_COMMUNICATION_MODE_SELECT];
    sh_load = en && r.txen && r.tx_pend && !sh_busy;
    addr_ph = hsel && htrans[1] && hready;
    addr_ok = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
    a_idx = addr_ok ? haddr[9:2] : 8'hff;
    rd_data = addr_ph && !hwrite && hit(a_idx, `DATA_IDX);
    wr_mc = r.wr_pend && hit(r.aidx, `MC_IDX);
    wr_cb = r.wr_pend && hit(r.aidx, `CB_IDX);
    wr_ie = r.wr_pend && hit(r.aidx, `IE_IDX);
    wr_if = r.wr_pend && hit(r.aidx, `IF_IDX);
    wr_st = r.wr_pend && hit(r.aidx, `ST_IDX);
    wr_data = r.wr_pend && hit(r.aidx, `DATA_IDX);
    if (en) begin
      mc_wval = (r.ctrl & ~`MC_PROT_FREE) | (hwdata & `MC_PROT_FREE);
    end else begin
      mc_wval = hwdata & `MC_WMASK;
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rdat = 32'h0000_0000;
    if (hit(a_idx, `MC_IDX)) begin
      rdat = r.ctrl;
    end else if (hit(a_idx, `CB_IDX)) begin
      rdat[`CB_START_FRAME_DETECT_ENABLE] = r.start_frame_detect_enable;
      rdat[`CB_TXEN] = r.txen;
      rdat[`CB_RXEN] = r.rxen;
    end else if (hit(a_idx, `IE_IDX)) begin
      rdat[7:0] = r.ie;
    end else if (hit(a_idx, `IF_IDX)) begin
      rdat[7:0] = flags(r);
    end else if (hit(a_idx, `ST_IDX)) begin
      rdat[`ST_OVF] = r.ovf;
      rdat[`ST_CTS] = r.cts_s[1];
      rdat[`ST_TXBUSY] = sh_busy;
      rdat[`ST_RXBUSY] = (r.rxst != RX_IDLE);
      rdat[`ST_SYNCBUSY] = 1'b0;
    end else if (hit(a_idx, `DATA_IDX)) begin
      rdat[7:0] = r.rxbuf;
    end
  end

  always_comb begin
    n = r;
    rx_done = 1'b0;
    n.cts_s = {r.cts_s[1:0], cts};
    n.rxd_s = {r.rxd_s[1:0], rxd};

    // Bus: zero-wait slave, read data captured at the address phase
    n.hready = 1'b1;
    n.hresp = 1'b0;
    n.wr_pend = addr_ph && hwrite;
    if (addr_ph) begin
      n.aidx = a_idx;
      if (!hwrite) begin
        n.hrdata = rdat;
      end
    end

    // Bit-rate dividers
    n.div = (!en || tick) ? 16'h0000 : 16'(r.div + 16'h0001);
    if (r.rdiv == 16'(BAUD_DIV - 1)) begin
      n.rdiv = 16'h0000;
    end else begin
      n.rdiv = 16'(r.rdiv + 16'h0001);
    end

    // Receiver
    case (r.rxst)
      RX_IDLE: begin
        if (start_det) begin
          n.rxst = RX_START;
          n.rdiv = 16'h0000;
        end
      end
      RX_START: begin
        if (rmid) begin
          n.rcnt = 3'h0;
          n.rxst = r.rxd_s[1] ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rmid) begin
          if (r.ctrl[`MC_BIT_ORDER_SELECT]) begin
            n.rsh = {r.rxd_s[1], r.rsh[7:1]};
          end else begin
            n.rsh = {r.rsh[6:0], r.rxd_s[1]};
          end
          n.rcnt = 3'(r.rcnt + 3'h1);
          if (r.rcnt == 3'h7) begin
            n.rxst = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rmid) begin
          rx_done = 1'b1;
          n.rxst = RX_IDLE;
        end
      end
      default: n.rxst = RX_IDLE;
    endcase
    if (!rx_on) begin
      n.rxst = RX_IDLE;
    end
    if (rx_done) begin
      n.rxbuf = r.rsh;
    end

    // Control words
    if (wr_mc) begin
      n.ctrl = mc_wval;
    end
    if (wr_cb) begin
      n.start_frame_detect_enable = hwdata[`CB_START_FRAME_DETECT_ENABLE];
      n.txen = hwdata[`CB_TXEN];
      n.rxen = hwdata[`CB_RXEN];
    end
    if (wr_ie) begin
      n.ie = hwdata[7:0];
    end

    // Transmit holding register
    if (sh_load) begin
      n.tx_pend = 1'b0;
    end
    if (wr_data) begin
      n.txbuf = hwdata[7:0];
      n.tx_pend = 1'b1;
    end

    // Sticky flags: a set in the same cycle as a clear wins
    if (wr_if && hwdata[`FL_CTS]) begin
      n.cts_f = 1'b0;
    end
    if (cts_chg) begin
      n.cts_f = 1'b1;
    end
    if (wr_if && hwdata[`FL_RXS]) begin
      n.rxs_f = 1'b0;
    end
    if (start_det && r.start_frame_detect_enable) begin
      n.rxs_f = 1'b1;
    end
    if ((wr_if && hwdata[`FL_TXC]) || wr_data) begin
      n.txc_f = 1'b0;
    end
    if (sh_done && !r.tx_pend) begin
      n.txc_f = 1'b1;
    end
    // Receive-complete and empty flags ignore flag-register writes
    if (rd_data || !rx_on) begin
      n.rx_full = 1'b0;
    end
    if (rx_done) begin
      n.rx_full = 1'b1;
    end
    if (wr_st && hwdata[`ST_OVF]) begin
      n.ovf = 1'b0;
    end
    if (rx_done && r.rx_full && !rd_data) begin
      n.ovf = 1'b1;
    end

    // Software reset returns every control and flag to reset value
    if (wr_mc && hwdata[`MC_SOFTWARE_RESET]) begin
      n.ctrl = `MC_RESET;
      n.start_frame_detect_enable = 1'b0;
      n.txen = 1'b0;
      n.rxen = 1'b0;
      n.ie = 8'h00;
      n.cts_f = 1'b0;
      n.rxs_f = 1'b0;
      n.txc_f = 1'b0;
      n.rx_full = 1'b0;
      n.tx_pend = 1'b0;
      n.ovf = 1'b0;
      n.rxst = RX_IDLE;
    end

    n.irq = |(flags(n) & n.ie);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= MAIN_RST;
    end else begin
      r <= n;
    end
  end

  serial_shifter u_shifter (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .mid(mid),
    .run(en && r.txen),
    .load(sh_load),
    .data(r.txbuf),
    .lsb_first(r.ctrl[`MC_BIT_ORDER_SELECT]),
    .sync_mode(r.ctrl[`MC_COMMUNICATION_MODE_SELECT]),
    .clock_polarity_select(r.ctrl[`MC_CLOCK_POLARITY_SELECT]),
    .txd(txd),
    .xck(xck),
    .busy(sh_busy),
    .done(sh_done)
  );

  assign hreadyout = r.hready;
  assign hrdata = r.hrdata;
  assign hresp = r.hresp;
  assign irq = r.irq;

  a_ctrl_immediate: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_mc && !hwdata[`MC_SOFTWARE_RESET]) |=> (r.ctrl == $past(mc_wval)))
    else $error("control word not updated in one cycle");

  a_cts_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (cts_chg && !(wr_mc && hwdata[`MC_SOFTWARE_RESET])) |=> r.cts_f)
    else $error("cts change did not set its flag");

  a_rxs_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (start_det && r.start_frame_detect_enable && !wr_mc) |=> r.rxs_f)
    else $error("start condition did not set its flag");

  a_rxc_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_data && !rx_done) |=> !r.rx_full)
    else $error("data read did not clear receive complete");

  a_txc_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (sh_done && !r.tx_pend && !wr_mc) |=> r.txc_f)
    else $error("frame end did not set transmit complete");

  a_txc_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_data && !sh_done) |=> !r.txc_f)
    else $error("data write did not clear transmit complete");

  a_dre_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_data && !wr_mc) |=> r.tx_pend)
    else $error("data write did not clear empty flag");

  a_zero_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_if && !hwdata[`FL_CTS] && r.cts_f) |=> r.cts_f)
    else $error("writing zero changed a flag");

  a_rxc_w1_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_if && hwdata[`FL_RXC] && r.rx_full && rx_on && !rd_data) |=> r.rx_full)
    else $error("writing one cleared receive complete");

  a_enable_protect: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_mc && en && !hwdata[`MC_SOFTWARE_RESET]) |=> (r.ctrl[31:2] == $past(r.ctrl[31:2])))
    else $error("protected control changed while enabled");

  a_software_reset_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_mc && hwdata[`MC_SOFTWARE_RESET]) |=> (r.ctrl == `MC_RESET) ##1 !irq)
    else $error("software reset left control nonzero");

  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == |(flags(r) & r.ie))
    else $error("interrupt output disagrees with flags");

endmodule // serial_port_control_and_flags

// ---- test/remote_serial_peer.sv ----
`timescale 1ns/1ns
module remote_serial_peer #(
  parameter int BAUD_DIV = 4
) (
  input wire logic hclk,
  input wire logic txd,
  output logic rxd,
  output logic cts
);
  logic [7:0] got;
  int frames;

  initial begin
    rxd = 1'b1;
    cts = 1'b0;
    got = 8'h00;
    frames = 0;
  end

  // Sends raw order: bit 0 of b leaves first
  task send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge hclk);
      rxd <= f[i];
      repeat (BAUD_DIV - 1) @(posedge hclk);
    end
  endtask

  task toggle_cts();
    @(posedge hclk);
    cts <= ~cts;
  endtask

  // Captures in arrival order, first bit into bit 0; falling edge sees settled txd
  initial begin
    forever begin
      @(negedge hclk);
      if (txd === 1'b0) begin
        repeat (BAUD_DIV / 2) @(negedge hclk);
        for (int i = 0; i < 8; i++) begin
          repeat (BAUD_DIV) @(negedge hclk);
          got[i] = txd;
        end
        repeat (BAUD_DIV) @(negedge hclk);
        frames++;
      end
    end
  end
endmodule // remote_serial_peer

// ---- test/serial_port_control_and_flags_tb_top.sv ----
`timescale 1ns/1ns
`include "serial_port_params.svh"
module serial_port_control_and_flags_tb_top;
  import serial_port_pkg::*;
  localparam int BD = 4;
  localparam logic [31:0] A_MC = 32'(`MC_IDX) << 2;
  localparam logic [31:0] A_CB = 32'(`CB_IDX) << 2;
  localparam logic [31:0] A_IE = 32'(`IE_IDX) << 2;
  localparam logic [31:0] A_IF = 32'(`IF_IDX) << 2;
  localparam logic [31:0] A_ST = 32'(`ST_IDX) << 2;
  localparam logic [31:0] A_DT = 32'(`DATA_IDX) << 2;
  localparam logic [31:0] FULL = 32'hffff_ffff;
  localparam logic [31:0] M5 = 32'h0000_001f;
  logic hclk, hresetn, hsel, hwrite, hready, hresp;
  logic rxd, cts, txd, xck, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int n_mismatch, checks, lows;

  serial_port_control_and_flags #(.BAUD_DIV(BD)) u_serial_port_control_and_flags (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .rxd(rxd), .cts(cts), .txd(txd), .xck(xck), .irq(irq)
  );

  remote_serial_peer #(.BAUD_DIV(BD)) u_remote_serial_peer (
    .hclk(hclk), .txd(txd), .rxd(rxd), .cts(cts)
  );

  always #2 hclk = ~hclk;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rdc(input logic [31:0] a, input logic [31:0] mask, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(rd & mask, exp);
  endtask

  task wait_frame(input int n);
    int k;
    k = 0;
    while (u_remote_serial_peer.frames < n && k < 400) begin
      @(posedge hclk);
      k++;
    end
    if (k >= 400) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: frame wait expired", $time);
    end
    repeat (3 * BD) @(posedge hclk);
  endtask

  task end_test(input string s);
    $display("test %s finished", s);
  endtask

  task report_and_stop();
    $display("comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    n_mismatch = 0;
    checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(A_MC, FULL, 32'h0000_0000);
    rdc(A_IF, FULL, 32'h0000_0001);
    rdc(A_ST, 32'h0000_8000, 32'h0000_0000);
    end_test("reset");
    wr(A_CB, 32'h0003_0200);
    // Order 0 then 1; disable first since the word is locked while enabled
    for (int o = 0; o < 2; o++) begin
      wr(A_MC, 32'h0000_0000);
      wr(A_MC, 32'(o) << 30);
      wr(A_MC, (32'(o) << 30) | 32'h0000_0002);
      wr(A_DT, 32'h0000_00b4);
      wait_frame(o + 1);
      chk(32'(u_remote_serial_peer.got), (o == 1) ? 32'h0000_00b4 : 32'h0000_002d);
      rdc(A_IF, M5, 32'h0000_0003);
    end
    chk(32'(irq), 32'h0000_0000);
    end_test("transmit");
    wr(A_IF, 32'h0000_0000);
    rdc(A_IF, M5, 32'h0000_0003);
    wr(A_IF, 32'h0000_0005);
    rdc(A_IF, M5, 32'h0000_0003);
    wr(A_DT, 32'h0000_003c);
    rdc(A_IF, 32'h0000_0002, 32'h0000_0000);
    wait_frame(3);
    chk(32'(u_remote_serial_peer.got), 32'h0000_003c);
    rdc(A_IF, M5, 32'h0000_0003);
    wr(A_IF, 32'h0000_0002);
    rdc(A_IF, M5, 32'h0000_0001);
    wr(A_MC, 32'h0000_0002);
    rdc(A_MC, FULL, 32'h4000_0002);
    end_test("flags");
    u_remote_serial_peer.send_byte(8'h5a);
    repeat (4 * BD) @(posedge hclk);
    rdc(A_IF, 32'h0000_000c, 32'h0000_000c);
    rdc(A_DT, 32'h0000_00ff, 32'h0000_005a);
    rdc(A_IF, 32'h0000_0004, 32'h0000_0000);
    wr(A_IF, 32'h0000_0008);
    rdc(A_IF, 32'h0000_0008, 32'h0000_0000);
    u_remote_serial_peer.send_byte(8'h81);
    repeat (4 * BD) @(posedge hclk);
    rdc(A_IF, 32'h0000_0004, 32'h0000_0004);
    wr(A_CB, 32'h0001_0200);
    rdc(A_IF, 32'h0000_0004, 32'h0000_0000);
    end_test("receive");
    wr(A_IE, 32'h0000_0010);
    u_remote_serial_peer.toggle_cts();
    repeat (8) @(posedge hclk);
    rdc(A_IF, 32'h0000_0010, 32'h0000_0010);
    chk(32'(irq), 32'h0000_0001);
    wr(A_IF, 32'h0000_0010);
    rdc(A_IF, 32'h0000_0010, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    rdc(32'h0000_03fc, FULL, 32'h0000_0000);
    end_test("cts");
    wr(A_MC, 32'h0000_0001);
    rdc(A_MC, FULL, 32'h0000_0000);
    rdc(A_IF, M5, 32'h0000_0001);
    wr(A_MC, 32'h2000_0000);
    repeat (2) @(posedge hclk);
    chk(32'(xck), 32'h0000_0001);
    wr(A_MC, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    chk(32'(xck), 32'h0000_0000);
    end_test("control");
    // Synchronous frame, polarity 1: one low half-bit per data bit
    wr(A_CB, 32'h0001_0000);
    wr(A_MC, 32'h3000_0000);
    wr(A_MC, 32'h3000_0002);
    wr(A_DT, 32'h0000_00ff);
    lows = 0;
    repeat (20 * BD) begin
      @(negedge hclk);
      if (xck === 1'b0) begin
        lows++;
      end
    end
    chk(32'(lows), 32'(8 * (BD / 2)));
    rdc(A_IF, 32'h0000_0002, 32'h0000_0002);
    end_test("sync");
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule // serial_port_control_and_flags_tb_top
